//--- rtl/radio_mode_enable_sequencer.sv
// Controller that drives the radio enables, trim cycle and coded transmit data
`timescale 1ns/1ps
module radio_mode_enable_sequencer #(
    parameter int TrimCycles = radio_seq_pkg::TRIM_MIN_US * radio_seq_pkg::CLK_MHZ,
    parameter int RxFirstCycles = radio_seq_pkg::RX_FIRST_US * radio_seq_pkg::CLK_MHZ,
    parameter int RetainCycles = radio_seq_pkg::RETAIN_S * radio_seq_pkg::CLK_MHZ * 1000000,
    parameter int PeriodCycles = radio_seq_pkg::TRIM_PERIOD_S * radio_seq_pkg::CLK_MHZ * 1000000
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    // Commands
    input wire logic cmdTrim,
    input wire logic cmdTx,
    input wire logic cmdRx,
    input wire logic cmdStop,
    input wire logic useExtSwitch,
    input wire logic autoTrim,
    input wire logic envChanged,
    // Payload bits
    input wire logic txBitValid,
    input wire logic txBit,
    input wire logic txBitLast,
    output logic txBitReady,
    // Status and receive data
    output logic busy,
    output radio_seq_pkg::seq_state_e mode,
    output logic trimDue,
    output logic rxValid,
    output logic rxDataOut,
    // Radio pins
    output radio_seq_pkg::radio_pins_s pins,
    input wire logic rxDataPin
);
    localparam int SettleCyc = radio_seq_pkg::SETTLE_US * radio_seq_pkg::CLK_MHZ;
    localparam int StoreCyc = radio_seq_pkg::STORE_US * radio_seq_pkg::CLK_MHZ;
    localparam int LockCyc = radio_seq_pkg::LOCK_US * radio_seq_pkg::CLK_MHZ;
    localparam int RampCyc = radio_seq_pkg::TX_RAMP_US * radio_seq_pkg::CLK_MHZ;
    localparam int RxFastCyc = radio_seq_pkg::RX_FAST_US * radio_seq_pkg::CLK_MHZ;
    localparam int HalfCyc = radio_seq_pkg::HALF_BIT_NS / radio_seq_pkg::CLK_NS;

    typedef struct packed {
        radio_seq_pkg::seq_state_e state;
        logic [31:0] timer;
        logic [31:0] trimAge;
        logic [31:0] chargeAge;
        logic charged;
        logic trimDue;
        logic [2:0] preCnt;
        logic [1:0] rxSync;
        logic rxOut;
        radio_seq_pkg::radio_pins_s pins;
    } seq_s;

    seq_s q;
    seq_s d;
    logic encValid;
    logic encBit;
    logic encReady;
    logic encLine;
    logic encBusy;
    logic trimClr;
    logic trimSet;

    manchester_encoder #(.HalfCycles(HalfCyc)) u_enc (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ce(ce),
        .bitValid(encValid),
        .bitIn(encBit),
        .bitReady(encReady),
        .line(encLine),
        .busy(encBusy)
    );

    // Preamble goes out before any payload bit is offered
    always_comb begin
        encValid = 1'b0;
        encBit = 1'b0;
        if (q.state == radio_seq_pkg::ST_TX_PRE) begin
            encValid = 1'b1; // R15
            encBit = radio_seq_pkg::PREAMBLE[3'd7 - q.preCnt];
        end else if (q.state == radio_seq_pkg::ST_TX_PAY) begin
            encValid = txBitValid;
            encBit = txBit;
        end
    end

    assign txBitReady = (q.state == radio_seq_pkg::ST_TX_PAY) && encReady;
    assign busy = (q.state != radio_seq_pkg::ST_IDLE);
    assign mode = q.state;
    assign trimDue = q.trimDue;
    assign rxValid = (q.state == radio_seq_pkg::ST_RX_ON);
    assign rxDataOut = q.rxOut;
    assign pins = q.pins;
    assign trimClr = (q.state == radio_seq_pkg::ST_TRIM_STORE) && (q.timer == 32'h0);
    assign trimSet = envChanged || (q.trimAge == 32'(PeriodCycles));

    function automatic radio_seq_pkg::radio_pins_s pinsFor(
        input radio_seq_pkg::seq_state_e st, input logic extSw, input logic data);
        radio_seq_pkg::radio_pins_s p;
        p = '0; // R1 R17
        unique case (st)
            radio_seq_pkg::ST_TRIM_SETTLE, radio_seq_pkg::ST_TRIM_STORE: p.synthEn = 1'b1; // R10
            radio_seq_pkg::ST_TRIM_RUN: begin
                p.synthEn = 1'b1; // R11
                p.trimEn = 1'b1;
            end
            radio_seq_pkg::ST_TX_LOCK: begin
                p.synthEn = 1'b1; // R4
                p.groundSw = !extSw; // R5
            end
            radio_seq_pkg::ST_TX_RAMP, radio_seq_pkg::ST_TX_PRE,
            radio_seq_pkg::ST_TX_PAY, radio_seq_pkg::ST_TX_DRAIN: begin
                p.synthEn = 1'b1; // R11
                p.groundSw = !extSw;
                p.txEn = 1'b1;
                p.txData = (st == radio_seq_pkg::ST_TX_RAMP) ? 1'b0 : data; // R6
            end
            radio_seq_pkg::ST_RX_WAIT, radio_seq_pkg::ST_RX_ON: p.rxEn = 1'b1; // R11
            default: p = '0;
        endcase
        return p;
    endfunction : pinsFor

    always_comb begin
        d = q;
        d.rxSync = {q.rxSync[0], rxDataPin};
        d.rxOut = q.rxSync[1];
        if (q.timer != 32'h0) begin
            d.timer = q.timer - 32'h1;
        end
        if (q.trimAge != 32'(PeriodCycles)) begin
            d.trimAge = q.trimAge + 32'h1;
        end
        // Age or a supply/temperature event raises the flag; a set beats a clear
        d.trimDue = (q.trimDue && !trimClr) || trimSet; // R12
        if (trimClr) begin
            d.trimAge = 32'h0;
        end
        // Bypass charge is trusted only for a limited time after receive ends
        if (q.pins.rxEn) begin
            d.chargeAge = 32'h0;
        end else if (q.chargeAge != 32'(RetainCycles)) begin
            d.chargeAge = q.chargeAge + 32'h1;
        end else begin
            d.charged = 1'b0; // R14
        end
        unique case (q.state)
            radio_seq_pkg::ST_IDLE: begin
                if (cmdTrim || (autoTrim && q.trimDue)) begin
                    d.state = radio_seq_pkg::ST_TRIM_SETTLE;
                    d.timer = 32'(SettleCyc - 1); // R7
                end else if (cmdTx) begin
                    d.state = radio_seq_pkg::ST_TX_LOCK;
                    d.timer = 32'(LockCyc - 1); // R4
                end else if (cmdRx) begin
                    d.state = radio_seq_pkg::ST_RX_WAIT;
                    d.timer = q.charged ? 32'(RxFastCyc - 1) : 32'(RxFirstCycles - 1); // R13 R14
                end
            end
            radio_seq_pkg::ST_TRIM_SETTLE: if (q.timer == 32'h0) begin
                d.state = radio_seq_pkg::ST_TRIM_RUN;
                d.timer = 32'(TrimCycles - 1); // R8
            end
            radio_seq_pkg::ST_TRIM_RUN: if (q.timer == 32'h0) begin
                d.state = radio_seq_pkg::ST_TRIM_STORE;
                d.timer = 32'(StoreCyc - 1); // R10
            end
            radio_seq_pkg::ST_TRIM_STORE: if (q.timer == 32'h0) begin
                d.state = radio_seq_pkg::ST_IDLE;
            end
            radio_seq_pkg::ST_TX_LOCK: if (q.timer == 32'h0) begin
                d.state = radio_seq_pkg::ST_TX_RAMP;
                d.timer = 32'(RampCyc - 1); // R6
            end
            radio_seq_pkg::ST_TX_RAMP: if (q.timer == 32'h0) begin
                d.state = radio_seq_pkg::ST_TX_PRE;
                d.preCnt = 3'h0;
            end
            radio_seq_pkg::ST_TX_PRE: if (encReady) begin
                d.preCnt = q.preCnt + 3'h1;
                if (q.preCnt == 3'(radio_seq_pkg::PRE_BITS - 1)) begin
                    d.state = radio_seq_pkg::ST_TX_PAY; // R15
                end
            end
            radio_seq_pkg::ST_TX_PAY: if (txBitValid && encReady && txBitLast) begin
                d.state = radio_seq_pkg::ST_TX_DRAIN;
            end
            radio_seq_pkg::ST_TX_DRAIN: if (!encBusy) begin
                d.state = radio_seq_pkg::ST_IDLE; // R17
            end
            radio_seq_pkg::ST_RX_WAIT: begin
                if (cmdStop) begin
                    d.state = radio_seq_pkg::ST_IDLE;
                end else if (q.timer == 32'h0) begin
                    d.state = radio_seq_pkg::ST_RX_ON;
                    d.charged = 1'b1;
                end
            end
            radio_seq_pkg::ST_RX_ON: if (cmdStop) begin
                d.state = radio_seq_pkg::ST_IDLE;
            end
            default: d.state = radio_seq_pkg::ST_IDLE;
        endcase
        d.pins = pinsFor(d.state, useExtSwitch, encLine);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    // Helper counters for the checks below
    logic [31:0] synthHigh;
    logic [31:0] trimHigh;
    logic [31:0] sinceTrimFall;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            synthHigh <= 32'h0;
            trimHigh <= 32'h0;
            sinceTrimFall <= 32'(StoreCyc);
        end else if (ce) begin
            synthHigh <= !q.pins.synthEn ? 32'h0 : synthHigh + {31'h0, synthHigh != 32'(SettleCyc)};
            trimHigh <= !q.pins.trimEn ? 32'h0 : trimHigh + {31'h0, trimHigh != 32'(TrimCycles)};
            if (q.pins.trimEn) begin
                sinceTrimFall <= 32'h0;
            end else if (sinceTrimFall != 32'(StoreCyc)) begin
                sinceTrimFall <= sinceTrimFall + 32'h1;
            end
        end
    end

    chk_tx_order: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
        $rose(pins.txEn) |-> $past(pins.synthEn) && (pins.groundSw || useExtSwitch))
        else $error("transmit enable rose before synthesizer and ground switch");
    chk_ext_switch: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
        ce && useExtSwitch && $past(useExtSwitch) && $past(ce) |-> !pins.groundSw)
        else $error("ground switch driven although external switch fitted");
    chk_ramp_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n) // R6
        $rose(pins.txEn) |-> !pins.txData)
        else $error("transmit data high at start of transmit power-up");
    chk_trim_settle: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
        $rose(pins.trimEn) |-> synthHigh >= 32'(SettleCyc))
        else $error("trim enable rose before synthesizer settled");
    chk_trim_length: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8
        $fell(pins.trimEn) |-> trimHigh >= 32'(TrimCycles))
        else $error("trim enable held too briefly");
    chk_store_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // R10
        (sinceTrimFall < 32'(StoreCyc)) |-> pins.synthEn)
        else $error("synthesizer dropped during trim storage");
    chk_synth_modes: assert property (@(posedge ref_clk) disable iff (!rst_n) // R11
        (pins.trimEn || pins.txEn) |-> pins.synthEn)
        else $error("synthesizer off during trim or transmit");
    chk_trim_due: assert property (@(posedge ref_clk) disable iff (!rst_n) // R12
        (ce && q.trimAge == 32'(PeriodCycles)) |=> trimDue)
        else $error("trim period expired without flag");
    chk_preamble_len: assert property (@(posedge ref_clk) disable iff (!rst_n) // R15
        (q.state == radio_seq_pkg::ST_TX_PAY && $past(q.state) == radio_seq_pkg::ST_TX_PRE)
        |-> q.preCnt == 3'h0)
        else $error("preamble not exactly eight bits");
    chk_no_overlap: assert property (@(posedge ref_clk) disable iff (!rst_n) // R17
        !(pins.txEn && pins.rxEn))
        else $error("transmit and receive enabled together");
endmodule : radio_mode_enable_sequencer

//--- rtl/radio_seq_pkg.sv
// Constants, pin carrier and states for the radio mode and enable sequencer
// Behaviour
// (R1) Device drops to standby by itself when every enable is low.
// (R2) Device powers receive, transmit and synthesizer chains from their enables.
// (R3) Device grounds its amplifier inputs while the ground switch is high; the model grounds them only while transmit enable is also high.
// (R4) Raise synthesizer and ground switch before transmit enable.
// (R5) With an external antenna switch the ground switch may stay low.
// (R6) Hold transmit data low while the transmit chain powers up.
// (R7) Raise synthesizer, wait 10 us, then raise trim enable.
// (R8) Trim runs while trim enable is high; hold it at least 100 us.
// (R9) Device stores trim result in about 10 us after trim enable falls.
// (R10) Keep synthesizer high through the storage interval after trim falls.
// (R11) Synthesizer on during trim and transmit; may be off while receiving.
// (R12) Repeat trim every one to ten seconds or after supply/temperature change.
// (R13) Received data valid about 700 us after the first receive enable.
// (R14) Charge holds at least one second; re-enable response about 7 us.
// (R15) Start every burst with an 8-bit preamble.
// (R16) Controller Manchester-encodes and sends 5 Mbps coded data.
// (R17) Never transmit and receive enabled together; all low for standby.
package radio_seq_pkg;
    localparam int CLK_MHZ = 100;
    localparam int CLK_NS = 10;
    localparam int SETTLE_US = 10;
    localparam int TRIM_MIN_US = 100;
    localparam int STORE_US = 10;
    localparam int LOCK_US = 25;
    localparam int TX_RAMP_US = 1;
    localparam int RX_FIRST_US = 700;
    localparam int RX_FAST_US = 7;
    localparam int RETAIN_S = 1;
    localparam int TRIM_PERIOD_S = 1;
    localparam int HALF_BIT_NS = 100;
    localparam int PRE_BITS = 8;
    localparam logic [7:0] PREAMBLE = 8'h55;

    typedef struct packed {
        logic rxEn;
        logic txEn;
        logic synthEn;
        logic trimEn;
        logic groundSw;
        logic txData;
    } radio_pins_s;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_TRIM_SETTLE = 4'h1,
        ST_TRIM_RUN = 4'h2,
        ST_TRIM_STORE = 4'h3,
        ST_TX_LOCK = 4'h4,
        ST_TX_RAMP = 4'h5,
        ST_TX_PRE = 4'h6,
        ST_TX_PAY = 4'h7,
        ST_TX_DRAIN = 4'h8,
        ST_RX_WAIT = 4'h9,
        ST_RX_ON = 4'hA
    } seq_state_e;
endpackage : radio_seq_pkg

//--- rtl/manchester_encoder.sv
// Manchester encoder: one bit becomes two half-bit symbols, the bit value then its inverse
`timescale 1ns/1ps
module manchester_encoder #(
    parameter int HalfCycles = 10
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    // Bit stream in
    input wire logic bitValid,
    input wire logic bitIn,
    output logic bitReady,
    // Coded line out
    output logic line,
    output logic busy
);
    localparam int CW = $clog2(HalfCycles);
    localparam logic [CW-1:0] LAST = CW'(HalfCycles - 1);

    typedef struct packed {
        logic busy;
        logic phase;
        logic bitv;
        logic [CW-1:0] cnt;
        logic line;
    } enc_s;

    enc_s q;
    enc_s d;
    logic take;

    // Ready in the last cycle of a bit lets bits follow with no gap
    assign bitReady = !q.busy || (q.phase && q.cnt == LAST);
    assign take = bitValid && bitReady;
    assign line = q.line;
    assign busy = q.busy;

    always_comb begin
        d = q;
        if (q.busy) begin
            if (q.cnt == LAST) begin
                d.cnt = '0;
                if (!q.phase) begin
                    d.phase = 1'b1;
                    d.line = ~q.bitv; // R16
                end else if (!take) begin
                    d.busy = 1'b0;
                    d.line = 1'b0;
                end
            end else begin
                d.cnt = q.cnt + CW'(1);
            end
        end
        if (take) begin
            d.busy = 1'b1;
            d.phase = 1'b0;
            d.bitv = bitIn;
            d.cnt = '0;
            d.line = bitIn; // R16
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    chk_half_width: assert property (@(posedge ref_clk) disable iff (!rst_n) // R16
        (ce && q.busy && q.cnt == LAST && !q.phase) |=> (line == !$past(q.bitv)))
        else $error("second half-bit is not the inverse of the first");
endmodule : manchester_encoder

//--- bench/radio_device_model.sv
// Behavioural radio device that answers the sequencer's enable pins
`timescale 1ns/1ps
module radio_device_model #(
    parameter int ChargeCycles = 100,
    parameter int HoldCycles = 500,
    parameter int StoreCycles = 990
) (
    // Clock
    input wire logic ref_clk,
    // Enable pins
    input wire radio_seq_pkg::radio_pins_s pins,
    // Device answers
    output logic rxDataPin,
    output logic standby,
    output logic [2:0] powered,
    output logic lnaGrounded,
    output logic trimStored
);
    int charge = 0;
    int idle = 0;
    int storeCnt = 0;
    int mseed = 32'h0123;
    assign standby = !(pins.rxEn | pins.txEn | pins.synthEn | pins.trimEn);
    assign powered = {pins.rxEn, pins.txEn, pins.synthEn};
    assign lnaGrounded = pins.groundSw & pins.txEn;
    assign trimStored = storeCnt > StoreCycles;
    initial rxDataPin = 1'b0;
    always @(posedge ref_clk) begin
        if (pins.rxEn) begin
            idle = 0;
            if (charge < ChargeCycles) charge++;
        end else if (idle < HoldCycles) idle++;
        else charge = 0;
        // Uncharged demodulator gives a toggling line, never a stale level
        if (pins.rxEn && charge >= ChargeCycles) rxDataPin <= 1'($random(mseed));
        else rxDataPin <= ~rxDataPin;
        // Store is lost if the synthesizer drops before it finishes
        if (pins.trimEn) storeCnt = 1;
        else if (storeCnt > 0 && storeCnt <= StoreCycles) storeCnt = pins.synthEn ? storeCnt + 1 : 0;
    end
endmodule : radio_device_model

//--- bench/tb_top.sv
// Self-checking bench for the radio mode and enable sequencer
`timescale 1ns/1ps
module tb_top;
    logic ref_clk = 0, rst_n = 0, ce = 1, cmdTrim = 0, cmdTx = 0, cmdRx = 0, cmdStop = 0;
    logic useExtSwitch = 0, autoTrim = 0, envChanged = 0;
    logic txBitValid = 0, txBit = 0, txBitLast = 0, txBitReady, busy, trimDue, rxValid;
    logic rxDataOut, rxDataPin, standby, lnaGrounded, trimStored;
    logic [2:0] powered, rxHist = 0;
    logic [15:0] payload = 0;
    radio_seq_pkg::seq_state_e mode;
    radio_seq_pkg::radio_pins_s pins;
    int err_total = 0, compares = 0, seed = 32'h6ce8, txIdx = 0, txN = 0, n, k;
    always #5 ref_clk = ~ref_clk;
    radio_mode_enable_sequencer #(.TrimCycles(50), .RxFirstCycles(100), .RetainCycles(500),
        .PeriodCycles(3000)) u_radio_mode_enable_sequencer (.ref_clk(ref_clk), .rst_n(rst_n),
        .ce(ce), .cmdTrim(cmdTrim), .cmdTx(cmdTx), .cmdRx(cmdRx), .cmdStop(cmdStop),
        .useExtSwitch(useExtSwitch), .autoTrim(autoTrim), .envChanged(envChanged),
        .txBitValid(txBitValid), .txBit(txBit), .txBitLast(txBitLast), .txBitReady(txBitReady),
        .busy(busy), .mode(mode), .trimDue(trimDue), .rxValid(rxValid), .rxDataOut(rxDataOut),
        .pins(pins), .rxDataPin(rxDataPin));
    radio_device_model u_radio_device_model (.ref_clk(ref_clk), .pins(pins),
        .rxDataPin(rxDataPin), .standby(standby), .powered(powered), .lnaGrounded(lnaGrounded),
        .trimStored(trimStored));
    task automatic summarize();
        if (err_total == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    function automatic logic pick(input int sel);
        case (sel)
            0: return pins.synthEn;
            1: return pins.trimEn;
            2: return pins.txEn;
            3: return pins.rxEn;
            4: return rxValid;
            default: return busy;
        endcase
    endfunction : pick
    // Bounded wait; returns cycles spent
    task automatic waitFor(input int sel, input logic lvl, input int bound, output int cnt);
        cnt = 0;
        while (pick(sel) !== lvl) begin
            @(posedge ref_clk);
            #1;
            cnt++;
            if (cnt > bound) begin
                err_total++;
                summarize();
            end
        end
    endtask : waitFor
    task automatic pulse(input int which);
        @(negedge ref_clk);
        {cmdTrim, cmdTx, cmdRx, cmdStop, envChanged} = 5'h10 >> which;
        @(negedge ref_clk);
        {cmdTrim, cmdTx, cmdRx, cmdStop, envChanged} = 5'h00;
    endtask : pulse
    function automatic logic expHalf(input int h);
        logic b;
        b = (h < 16) ? radio_seq_pkg::PREAMBLE[7 - h / 2] : payload[h / 2 - 8];
        return (h % 2 == 0) ? b : !b;
    endfunction : expHalf
    always @(negedge ref_clk) begin
        txBitValid <= txIdx < txN;
        txBit <= payload[txIdx[3:0]];
        txBitLast <= txIdx == txN - 1;
        if (rst_n) begin
            check("txAndRx", pins.txEn & pins.rxEn, 0);
            check("txNeedsSynth", pins.txEn & !pins.synthEn, 0);
            check("trimNeedsSynth", pins.trimEn & !pins.synthEn, 0);
            check("earlyReady", txBitReady & (mode !== radio_seq_pkg::ST_TX_PAY), 0);
            if (rxValid) check("rxData", rxDataOut, rxHist[2]);
        end
    end
    always @(posedge ref_clk) begin
        rxHist <= {rxHist[1:0], rxDataPin};
        if (txBitValid && txBitReady) txIdx <= txIdx + 1;
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk) rst_n = 1;
        @(posedge ref_clk) #1;
        check("pinsReset", pins, 0);
        check("modeReset", mode, radio_seq_pkg::ST_IDLE);
        check("standby", standby, 1);
        pulse(4);
        repeat (2) @(posedge ref_clk) #1;
        check("dueSet", trimDue, 1);
        @(negedge ref_clk) autoTrim = 1;
        waitFor(0, 1, 6, n);
        @(negedge ref_clk) autoTrim = 0;
        waitFor(1, 1, 1100, n);
        check("settle", n >= 998 && n <= 1002, 1);
        pulse(1);
        check("txRefused", mode, radio_seq_pkg::ST_TRIM_RUN);
        waitFor(1, 0, 60, n);
        check("trimLen", n >= 47 && n <= 51, 1);
        waitFor(0, 0, 1100, n);
        check("storeHold", n >= 998, 1);
        check("stored", trimStored, 1);
        check("dueClear", trimDue, 0);
        for (int ext = 0; ext < 2; ext++) begin
            @(negedge ref_clk) useExtSwitch = ext[0];
            payload = 16'($random(seed));
            txN = 4 + ($random(seed) & 32'h7);
            txIdx = 0;
            pulse(1);
            waitFor(0, 1, 6, n);
            check("groundSw", pins.groundSw, !ext[0]);
            waitFor(2, 1, 2600, n);
            check("lockWait", n >= 2495 && n <= 2505, 1);
            check("lnaGround", lnaGrounded, !ext[0]);
            for (k = 0; k < 99; k++) begin
                check("rampLow", pins.txData, 0);
                @(posedge ref_clk) #1;
            end
            repeat (6) @(posedge ref_clk) #1;
            for (k = 0; k < 2 * (8 + txN); k++) begin
                check("halfBit", pins.txData, expHalf(k));
                repeat (10) @(posedge ref_clk) #1;
            end
            waitFor(5, 0, 200, n);
            check("txEndPins", pins, 0);
        end
        pulse(2);
        waitFor(3, 1, 6, n);
        check("rxPowered", powered[2], 1);
        waitFor(4, 1, 120, n);
        check("rxFirst", n >= 95 && n <= 105, 1);
        repeat (50) @(posedge ref_clk);
        pulse(3);
        waitFor(3, 0, 6, n);
        pulse(2);
        waitFor(3, 1, 6, n);
        waitFor(4, 1, 800, n);
        check("rxFast", n >= 690 && n <= 710, 1);
        pulse(3);
        waitFor(5, 0, 10, n);
        check("standbyEnd", standby, 1);
        check("dueAged", trimDue, 1);
        pulse(0);
        waitFor(1, 1, 1100, n);
        check("cmdSettle", n >= 998 && n <= 1002, 1);
        // Twenty frozen edges must stretch the trim phase by that much, within two cycles
        @(negedge ref_clk) ce = 0;
        repeat (20) @(negedge ref_clk);
        ce = 1;
        waitFor(1, 0, 80, n);
        check("ceFreeze", n >= 48 && n <= 52, 1);
        waitFor(0, 0, 1100, n);
        check("dueSetWins", trimDue, 1);
        summarize();
    end
endmodule : tb_top
